// ===== cmr_pkg.sv
package cmr_pkg;

  // Byte offsets of the word registers on the bus
  localparam logic [11:0] OFS_INSTR       = 12'h000;
  localparam logic [11:0] OFS_WORK        = 12'h004;
  localparam logic [11:0] OFS_PROD_HIGH   = 12'h008;
  localparam logic [11:0] OFS_PROD_LOW    = 12'h00C;
  localparam logic [11:0] OFS_ALU_FLAGS   = 12'h010;
  localparam logic [11:0] OFS_CPU_STATUS  = 12'h014;
  localparam logic [11:0] OFS_PC          = 12'h018;
  localparam logic [11:0] OFS_STACK_TOP   = 12'h01C;
  localparam logic [11:0] OFS_PC_LATCH    = 12'h020;
  localparam logic [11:0] OFS_IND_ADDR    = 12'h024;
  localparam logic [11:0] OFS_EXEC_STATUS = 12'h028;
  // Data memory window: one byte per word, 256 words
  localparam logic [1:0]  DMEM_SEL        = 2'h1;

  // Field positions
  localparam int FLAG_C        = 0;
  localparam int FLAG_DC       = 1;
  localparam int FLAG_Z        = 2;
  localparam int FLAG_OV       = 3;
  localparam int GLOBAL_INTERRUPT_DISABLE_BIT    = 4;
  localparam int EXEC_BUSY     = 0;
  localparam int EXEC_NOP      = 1;
  localparam int EXEC_PHASE_LO = 2;
  localparam int EXEC_UNSUP    = 4;

  // Reset values and the indirect location
  localparam logic [7:0]  CPU_STATUS_RST = 8'h10;
  localparam logic [7:0]  BYTE_RST       = 8'h00;
  localparam logic [15:0] WORD_RST       = 16'h0000;
  localparam logic [7:0]  IND_LOCATION   = 8'h00;

  // Instruction encodings
  localparam logic [2:0]  OPC_MOVE_PF  = 3'h2;
  localparam logic [7:0]  OPC_MOVE_WF  = 8'h01;
  localparam logic [7:0]  OPC_MUL_LIT  = 8'hBC;
  localparam logic [7:0]  OPC_MUL_FILE = 8'h34;
  localparam logic [6:0]  OPC_NEGATE   = 7'h16;
  localparam logic [15:0] OPC_RET_INT  = 16'h0005;
  localparam logic [7:0]  OPC_RET_LIT  = 8'hB6;

  typedef enum logic [1:0] {Q_DECODE, Q_READ, Q_PROCESS, Q_WRITE} cmr_phase_t;

  typedef enum logic [2:0] {
    OP_NONE, OP_MOVE_PF, OP_MOVE_WF, OP_MUL_LIT, OP_MUL_FILE, OP_NEGATE, OP_RET_INT, OP_RET_LIT
  } cmr_op_t;

endpackage

// ===== cmr_alu_if.sv
`timescale 1ns/1ps
interface cmr_alu_if;
  logic [7:0]  work;
  logic [7:0]  operand;
  logic [15:0] product;
  logic [7:0]  neg_value;
  logic [3:0]  neg_flags;
  modport core (output work, output operand, input product, input neg_value, input neg_flags);
  modport alu  (input work, input operand, output product, output neg_value, output neg_flags);
endinterface

// ===== cmr_alu.sv
`timescale 1ns/1ps
module cmr_alu (
  cmr_alu_if.alu bus
);
  import cmr_pkg::*;

  logic [8:0] neg_sum;
  logic [4:0] low_sum;

  // Unsigned 8x8 product; never overflows 16 bits
  assign bus.product = 16'(bus.work) * 16'(bus.operand);

  // Two's complement as inverted plus one, keeping the carries
  assign neg_sum       = {1'b0, ~bus.work} + 9'h001;
  assign low_sum       = {1'b0, ~bus.work[3:0]} + 5'h01;
  assign bus.neg_value = neg_sum[7:0];
  // 00h and 80h negate to themselves; 80h is the single signed overflow
  always_comb begin
    bus.neg_flags          = 4'h0;
    bus.neg_flags[FLAG_C]  = neg_sum[8];
    bus.neg_flags[FLAG_DC] = low_sum[4];
    bus.neg_flags[FLAG_Z]  = (neg_sum[7:0] == 8'h00);
    bus.neg_flags[FLAG_OV] = (bus.work == 8'h80);
  end
endmodule

// ===== cmr_phase_seq.sv
`timescale 1ns/1ps
module cmr_phase_seq (
  input  wire logic               sys_clk,
  input  wire logic               nrst,
  input  wire logic               start,
  input  wire logic               two_cycle,
  output cmr_pkg::cmr_phase_t     phase,
  output logic                    busy,
  output logic                    nop_cycle
);
  import cmr_pkg::*;

  typedef struct packed {
    logic       busy;
    logic       nop_cycle;
    cmr_phase_t phase;
  } cmr_seq_state_t;

  cmr_seq_state_t st;
  cmr_seq_state_t next_st;

  // Four phases per cycle; a return adds one whole idle cycle
  always_comb begin
    next_st = st;
    if (!st.busy) begin
      if (start) begin
        next_st.busy      = 1'b1;
        next_st.nop_cycle = 1'b0;
        next_st.phase     = Q_DECODE;
      end
    end else if (st.phase == Q_WRITE) begin
      next_st.phase = Q_DECODE;
      if (!st.nop_cycle && two_cycle) begin
        next_st.nop_cycle = 1'b1; // RULE14
      end else begin
        next_st.busy      = 1'b0;
        next_st.nop_cycle = 1'b0;
      end
    end else begin
      next_st.phase = cmr_phase_t'(st.phase + 2'h1);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '{busy: 1'b0, nop_cycle: 1'b0, phase: Q_DECODE};
    end else begin
      st <= next_st;
    end
  end

  assign phase     = st.phase;
  assign busy      = st.busy;
  assign nop_cycle = st.nop_cycle;
endmodule

// ===== cmr_core.sv
`timescale 1ns/1ps
// Behaviour
// (RULE1) Move-peripheral-to-file copies window to data in one cycle, either side indirect.
// (RULE2) Its opcode is 010 then a 5-bit source 00h-1Fh and an 8-bit destination 00h-FFh.
// (RULE3) Move-working-to-file, 0000 0001 plus address, stores the working register, no flags.
// (RULE4) That destination can be any of the 256 data locations.
// (RULE5) Multiply-by-literal, 1011 1100 plus literal, loads the product pair in one cycle.
// (RULE6) Multiply-by-file, 0011 0100 plus address, loads the product pair, sources kept.
// (RULE7) Neither multiply touches a flag, not even zero, nor the working register.
// (RULE8) Negate, 0010 110s plus address, stores the negation, in the working reg if s is 0.
// (RULE9) Negate updates overflow, carry, digit carry and zero from its result.
// (RULE10) Return-from-interrupt, 0000 0000 0000 0101, pops pc, clears disable, two cycles.
// (RULE11) The interrupt disable flag is bit 4 of the cpu status register.
// (RULE12) Return-with-literal, 1011 0110 plus literal, loads the working reg and pops the pc.
// (RULE13) Return-with-literal keeps the program counter high latch unchanged.
// (RULE14) A cycle is decode, read, process, write; returns pop in write, then idle a cycle.
module cmr_core (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output cmr_pkg::cmr_phase_t exec_phase,
  output logic             exec_busy
);
  import cmr_pkg::*;

  // Architectural registers, the latches of the running instruction and the bus data phase latches
  typedef struct packed {
    logic [7:0]  working_register;
    logic [7:0]  product_high_byte;
    logic [7:0]  product_low_byte;
    logic [3:0]  alu_flags;
    logic [7:0]  cpu_status_register;
    logic [15:0] pc;
    logic [15:0] stack_top_value;
    logic [7:0]  pc_high_holding_latch;
    logic [7:0]  ind_addr;
    logic [15:0] instr;
    cmr_op_t     op;
    logic [7:0]  src_addr;
    logic [7:0]  dst_addr;
    logic [7:0]  operand;
    logic [7:0]  result;
    logic        unsupported;
    logic        dp_wr;
    logic [11:0] dp_addr;
    logic [31:0] rdata;
  } cmr_core_state_t;

  // Registered state, its next value and the 256 data locations, which are not reset
  cmr_core_state_t st;
  cmr_core_state_t next_st;
  logic [7:0]      dmem [0:255];

  // Links to the arithmetic unit and the sequencer, plus the memory port controls
  cmr_alu_if  alu_bus ();
  cmr_phase_t phase;
  cmr_op_t    dec_op;
  logic       nop_cycle;
  logic       start;
  logic       two_cycle;
  logic       addr_req;
  logic       rd_req;
  logic       mem_we;
  logic [7:0] mem_wa;
  logic [7:0] mem_wd;

  // Multiplier and negator, purely combinational
  cmr_alu u_alu (
    .bus (alu_bus.alu)
  );

  // Phase sequencer; owns busy and the idle second cycle of the returns
  cmr_phase_seq u_seq (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .start     (start),
    .two_cycle (two_cycle),
    .phase     (phase),
    .busy      (exec_busy),
    .nop_cycle (nop_cycle)
  );

  // Operands for the multiplier and negator stay stable through the write phase
  assign alu_bus.work    = st.working_register;
  assign alu_bus.operand = st.operand;

  // Bus request decode; a read right behind a write waits one cycle so it sees the new value
  assign addr_req  = hsel && hready && htrans[1];
  assign rd_req    = hsel && htrans[1] && !hwrite;
  assign hreadyout = !(st.dp_wr && rd_req);
  assign hresp     = 1'b0;
  assign hrdata    = st.rdata;

  // Writing the instruction register while idle launches one instruction
  assign start     = st.dp_wr && (st.dp_addr == OFS_INSTR) && !exec_busy;
  assign two_cycle = (st.op == OP_RET_INT) || (st.op == OP_RET_LIT); // RULE10 RULE12

  // Instruction decode
  function automatic cmr_op_t decode_op(input logic [15:0] ins);
    cmr_op_t op;
    op = OP_NONE;
    if (ins[15:13] == OPC_MOVE_PF) op = OP_MOVE_PF; // RULE2
    else if (ins[15:8] == OPC_MOVE_WF) op = OP_MOVE_WF; // RULE3
    else if (ins[15:8] == OPC_MUL_LIT) op = OP_MUL_LIT; // RULE5
    else if (ins[15:8] == OPC_MUL_FILE) op = OP_MUL_FILE; // RULE6
    else if (ins[15:9] == OPC_NEGATE) op = OP_NEGATE; // RULE8
    else if (ins == OPC_RET_INT) op = OP_RET_INT; // RULE10
    else if (ins[15:8] == OPC_RET_LIT) op = OP_RET_LIT; // RULE12
    return op;
  endfunction

  // Decoded once from the instruction register, read only in the decode phase
  assign dec_op = decode_op(st.instr);

  // Location zero stands for the location held in the indirect address register
  function automatic logic [7:0] resolve(input logic [7:0] a, input logic [7:0] ind);
    return (a == IND_LOCATION) ? ind : a;
  endfunction

  // Register read mux, evaluated in the address phase
  function automatic logic [31:0] read_word(input cmr_core_state_t s, input logic [11:0] a,
                                            input logic [7:0] mbyte, input logic [3:0] ex);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (a[11:10] == DMEM_SEL) begin
      d[7:0] = mbyte;
    end else begin
      case (a)
        OFS_INSTR:       d[15:0] = s.instr;
        OFS_WORK:        d[7:0]  = s.working_register;
        OFS_PROD_HIGH:   d[7:0]  = s.product_high_byte;
        OFS_PROD_LOW:    d[7:0]  = s.product_low_byte;
        OFS_ALU_FLAGS:   d[3:0]  = s.alu_flags;
        OFS_CPU_STATUS:  d[7:0]  = s.cpu_status_register;
        OFS_PC:          d[15:0] = s.pc;
        OFS_STACK_TOP:   d[15:0] = s.stack_top_value;
        OFS_PC_LATCH:    d[7:0]  = s.pc_high_holding_latch;
        OFS_IND_ADDR:    d[7:0]  = s.ind_addr;
        OFS_EXEC_STATUS: d[4:0]  = {s.unsupported, ex};
        default:         d       = 32'h0000_0000;
      endcase
    end
    return d;
  endfunction

  // Bus side and execution side share one next-state copy; execution writes come last
  always_comb begin
    next_st = st;
    // Memory port defaults to the bus data phase address
    mem_we  = 1'b0;
    mem_wa  = st.dp_addr[9:2];
    mem_wd  = hwdata[7:0];
    // Bus data phase of a write; the instruction register is locked while running
    if (st.dp_wr) begin
      next_st.dp_wr = 1'b0;
      if (st.dp_addr[11:10] == DMEM_SEL) begin
        // Data memory window, one byte per word
        mem_we = 1'b1;
      end else begin
        case (st.dp_addr)
          OFS_INSTR:      if (!exec_busy) next_st.instr = hwdata[15:0];
          OFS_WORK:       next_st.working_register = hwdata[7:0];
          OFS_PROD_HIGH:  next_st.product_high_byte = hwdata[7:0];
          OFS_PROD_LOW:   next_st.product_low_byte = hwdata[7:0];
          OFS_ALU_FLAGS:  next_st.alu_flags = hwdata[3:0];
          OFS_CPU_STATUS: next_st.cpu_status_register = hwdata[7:0];
          OFS_PC:         next_st.pc = hwdata[15:0];
          OFS_STACK_TOP:  next_st.stack_top_value = hwdata[15:0];
          OFS_PC_LATCH:   next_st.pc_high_holding_latch = hwdata[7:0];
          OFS_IND_ADDR:   next_st.ind_addr = hwdata[7:0];
          default:        next_st.dp_wr = 1'b0;
        endcase
      end
    end
    // Bus address phase
    if (addr_req) begin
      next_st.dp_wr   = hwrite;
      next_st.dp_addr = haddr[11:0];
      // Read data is captured now and stands until the next read is taken
      if (!hwrite) begin
        next_st.rdata = read_word(st, haddr[11:0], dmem[haddr[9:2]],
                                  {phase, nop_cycle, exec_busy});
      end
    end
    // Execution; the idle second cycle of a return does nothing
    if (exec_busy && !nop_cycle) begin
      case (phase)
        Q_DECODE: begin
          // Latch the operation and resolve both addresses
          next_st.op          = dec_op;
          next_st.unsupported = (dec_op == OP_NONE);
          if (dec_op == OP_MOVE_PF) begin
            next_st.src_addr = resolve({3'h0, st.instr[12:8]}, st.ind_addr); // RULE1 RULE2
          end else begin
            next_st.src_addr = resolve(st.instr[7:0], st.ind_addr);
          end
          next_st.dst_addr = resolve(st.instr[7:0], st.ind_addr); // RULE1 RULE4
        end
        Q_READ: begin
          // Literal forms take the low byte, the rest read the source location
          if (st.op == OP_MUL_LIT || st.op == OP_RET_LIT) begin
            next_st.operand = st.instr[7:0];
          end else begin
            next_st.operand = dmem[st.src_addr];
          end
        end
        Q_PROCESS: begin
          // Move and negate results are latched here; products and negate flags come from the ALU in the write phase
          case (st.op)
            OP_MOVE_PF: next_st.result = st.operand; // RULE1
            OP_MOVE_WF: next_st.result = st.working_register; // RULE3
            OP_NEGATE:  next_st.result = alu_bus.neg_value; // RULE8
            OP_RET_INT: next_st.cpu_status_register[GLOBAL_INTERRUPT_DISABLE_BIT] = 1'b0; // RULE10 RULE11
            default:    next_st.result = st.result;
          endcase
        end
        Q_WRITE: begin
          // Returns reload the counter from the stack top; the high latch is never touched
          if (two_cycle) begin
            next_st.pc = st.stack_top_value; // RULE10 RULE13 RULE14
          end else begin
            next_st.pc = st.pc + 16'h0001;
          end
          // Only storing instructions claim the memory port; a bus store beside any other lands
          case (st.op)
            OP_MOVE_PF: begin
              mem_we                    = 1'b1; // RULE1
              mem_wa                    = st.dst_addr;
              mem_wd                    = st.result;
              next_st.alu_flags[FLAG_Z] = (st.result == 8'h00);
            end
            OP_MOVE_WF: begin
              mem_we = 1'b1; // RULE3 RULE4
              mem_wa = st.dst_addr;
              mem_wd = st.result;
            end
            OP_MUL_LIT, OP_MUL_FILE: begin
              // Flags and working register are left as they are
              next_st.product_high_byte = alu_bus.product[15:8]; // RULE5 RULE6 RULE7
              next_st.product_low_byte  = alu_bus.product[7:0]; // RULE5 RULE6
            end
            OP_NEGATE: begin
              mem_we            = 1'b1; // RULE8
              mem_wa            = st.dst_addr;
              mem_wd            = st.result;
              next_st.alu_flags = alu_bus.neg_flags; // RULE9
              if (!st.instr[8]) next_st.working_register = st.result; // RULE8
            end
            OP_RET_LIT: next_st.working_register = st.operand; // RULE12
            default:    next_st.result = st.result;
          endcase
        end
        default: next_st.result = st.result;
      endcase
    end
  end

  // Execution store wins over a bus store to data memory in the same cycle
  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      dmem[mem_wa] <= mem_wd;
    end
  end

  // State register; reset gives each field exactly one idle value
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st.working_register      <= BYTE_RST;
      st.product_high_byte     <= BYTE_RST;
      st.product_low_byte      <= BYTE_RST;
      st.alu_flags             <= '0;
      st.cpu_status_register   <= CPU_STATUS_RST;
      st.pc                    <= WORD_RST;
      st.stack_top_value       <= WORD_RST;
      st.pc_high_holding_latch <= BYTE_RST;
      st.ind_addr              <= BYTE_RST;
      st.instr                 <= WORD_RST;
      st.op                    <= OP_NONE;
      st.src_addr              <= BYTE_RST;
      st.dst_addr              <= BYTE_RST;
      st.operand               <= BYTE_RST;
      st.result                <= BYTE_RST;
      st.unsupported           <= 1'b0;
      st.dp_wr                 <= 1'b0;
      st.dp_addr               <= '0;
      st.rdata                 <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Phase leaves straight from the sequencer flop
  assign exec_phase = phase;
endmodule

// ===== cmr_core_assertions.sv
`timescale 1ns/1ps
module cmr_core_assertions (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input cmr_pkg::cmr_phase_t exec_phase,
  input wire logic        exec_busy
);
  import cmr_pkg::*;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  logic       go;
  logic [3:0] run_len;

  // Instruction write taken while the core is idle
  assign go = hsel && hready && htrans[1] && hwrite && haddr[11:0] == OFS_INSTR && !exec_busy;

  // Busy cycles seen in a row; a run longer than two instruction cycles is a hang
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      run_len <= 4'h0;
    end else begin
      run_len <= exec_busy ? run_len + 4'h1 : 4'h0;
    end
  end

  sequence s_cycle;
    exec_phase == Q_DECODE ##1 exec_phase == Q_READ ##1 exec_phase == Q_PROCESS
      ##1 exec_phase == Q_WRITE;
  endsequence

  a_first_cycle: assert property ($rose(exec_busy) |-> s_cycle)
    else $error("phase order broken");
  a_cycle_end: assert property (exec_busy && exec_phase == Q_WRITE |=>
    !exec_busy || exec_phase == Q_DECODE) else $error("bad phase after write");
  a_busy_steady: assert property (exec_busy && exec_phase != Q_WRITE |=> exec_busy)
    else $error("busy dropped mid cycle");
  a_run_limit: assert property (exec_busy |-> run_len < 4'h8)
    else $error("instruction ran too long");
  a_launch_delay: assert property (go |-> ##2 $rose(exec_busy))
    else $error("instruction not launched");
  a_wait_one: assert property (!hreadyout |=> hreadyout)
    else $error("wait state too long");
  a_okay_resp: assert property (hresp == 1'b0)
    else $error("error response");
  a_rdata_hold: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
    else $error("read data moved");
endmodule

bind cmr_core cmr_core_assertions cmr_core_assertions_i (.sys_clk, .nrst, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .exec_phase, .exec_busy);

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
  import cmr_pkg::*;
  logic        sys_clk;
  logic        nrst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  cmr_phase_t  exec_phase;
  logic        exec_busy;
  int          n_mismatch;
  int          n_tests;

  cmr_core cmr_core_i (.sys_clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .exec_phase, .exec_busy);

  // Verdict, shared by the main sequence and the watchdog
  task automatic finish_test();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One single word transfer; each phase is held until hready is seen high
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {20'h0, a};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wr ? wd : 32'h0;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0, x);
    check(x, exp);
  endtask

  // Byte address of data location n
  function automatic logic [11:0] ma(input logic [7:0] n);
    return 12'h400 | {2'h0, n, 2'h0};
  endfunction

  // Launch one instruction and count its busy cycles until it retires
  task automatic run(input logic [15:0] op, input int cyc);
    int n;
    n = 0;
    wr(OFS_INSTR, {16'h0, op});
    @(posedge sys_clk);
    while (exec_busy === 1'b1 && n < 40) begin
      n++;
      @(posedge sys_clk);
    end
    check(32'(n), 32'(cyc));
  endtask

  task automatic t_reset();
    rchk(OFS_CPU_STATUS, 32'h10);
    rchk(OFS_WORK, 32'h0);
    rchk(12'h0FC, 32'h0);
    rchk(OFS_EXEC_STATUS, 32'h0);
  endtask

  // Direct and indirect window moves, then a working move to the top location
  task automatic t_move();
    wr(ma(8'h1F), 32'h11);
    wr(ma(8'h80), 32'h33);
    run(16'h5F80, 4);
    rchk(ma(8'h80), 32'h11);
    wr(OFS_IND_ADDR, 32'h90);
    wr(ma(8'h90), 32'h5A);
    run(16'h4081, 4);
    rchk(ma(8'h81), 32'h5A);
    run(16'h5F00, 4);
    rchk(ma(8'h90), 32'h11);
    wr(OFS_WORK, 32'h4F);
    wr(OFS_ALU_FLAGS, 32'hF);
    run(16'h01FF, 4);
    rchk(ma(8'hFF), 32'h4F);
    rchk(OFS_ALU_FLAGS, 32'hF);
  endtask

  // Zero product row starts with clear flags so a raised zero flag shows
  task automatic t_mul();
    logic [7:0]  w [4] = '{8'hE2, 8'hFF, 8'h00, 8'hC4};
    logic [7:0]  k [4] = '{8'hC4, 8'hFF, 8'h55, 8'hB5};
    logic [15:0] p;
    logic [31:0] fl;
    for (int i = 0; i < 4; i++) begin
      p = 16'(w[i]) * 16'(k[i]);
      fl = (i == 2) ? 32'h0 : 32'hF;
      wr(OFS_WORK, {24'h0, w[i]});
      wr(OFS_ALU_FLAGS, fl);
      if (i < 3) begin
        run({8'hBC, k[i]}, 4);
      end else begin
        wr(ma(8'h40), {24'h0, k[i]});
        run({8'h34, 8'h40}, 4);
        rchk(ma(8'h40), {24'h0, k[i]});
      end
      rchk(OFS_PROD_HIGH, {24'h0, p[15:8]});
      rchk(OFS_PROD_LOW, {24'h0, p[7:0]});
      rchk(OFS_WORK, {24'h0, w[i]});
      rchk(OFS_ALU_FLAGS, fl);
    end
  endtask

  // Odd rows set the store-only bit
  task automatic t_neg();
    logic [7:0] w [3] = '{8'h3A, 8'h80, 8'h00};
    logic [7:0] r;
    logic [3:0] fl;
    for (int i = 0; i < 3; i++) begin
      r = 8'h00 - w[i];
      fl = {w[i] == 8'h80, r == 8'h00, w[i][3:0] == 4'h0, w[i] == 8'h00};
      wr(OFS_WORK, {24'h0, w[i]});
      wr(ma(8'h50), 32'hAB);
      run({7'h16, i[0], 8'h50}, 4);
      rchk(ma(8'h50), {24'h0, r});
      rchk(OFS_WORK, {24'h0, i[0] ? w[i] : r});
      rchk(OFS_ALU_FLAGS, {28'h0, fl});
    end
  endtask

  task automatic t_ret();
    wr(OFS_PC_LATCH, 32'h56);
    wr(OFS_STACK_TOP, 32'h1234);
    wr(OFS_CPU_STATUS, 32'h10);
    run(16'h0005, 8);
    rchk(OFS_PC, 32'h1234);
    rchk(OFS_CPU_STATUS, 32'h0);
    rchk(OFS_PC_LATCH, 32'h56);
    wr(OFS_STACK_TOP, 32'h2345);
    run(16'hB6A7, 8);
    rchk(OFS_WORK, 32'hA7);
    rchk(OFS_PC, 32'h2345);
    rchk(OFS_PC_LATCH, 32'h56);
  endtask

  // A second launch lands while busy and must leave the product alone
  task automatic t_busy();
    wr(OFS_WORK, 32'h02);
    wr(OFS_INSTR, 32'h0105);
    run(16'hBC03, 2);
    rchk(ma(8'h05), 32'h02);
    rchk(OFS_PROD_LOW, 32'h94);
  endtask

  // Bus stores beside a multiply, the last in its write phase; then an unknown code
  task automatic t_overlap();
    wr(ma(8'h07), 32'hC3);
    wr(OFS_WORK, 32'h03);
    wr(OFS_INSTR, 32'hBC07);
    wr(ma(8'h60), 32'h61);
    wr(ma(8'h61), 32'h62);
    rchk(ma(8'h61), 32'h62);
    rchk(ma(8'h07), 32'hC3);
    rchk(OFS_PROD_LOW, 32'h15);
    rchk(OFS_WORK, 32'h03);
    run(16'h0000, 4);
    rchk(OFS_EXEC_STATUS, 32'h10);
    rchk(OFS_PC, 32'h2348);
  endtask

  // Free running 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Watchdog well beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    finish_test();
  end

  // Reset, then the scenarios in order
  initial begin
    n_mismatch = 0;
    n_tests = 0;
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_move();
    t_mul();
    t_neg();
    t_ret();
    t_busy();
    t_overlap();
    finish_test();
  end
endmodule
